// [src/sdr_consts.svh]
// Character codes, limits and reset values of the sensor command responder.
// Assumes 8-bit ASCII characters delivered by a separate serial front end.
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH
`define SDR_CH_BANG   8'h21
`define SDR_CH_QUERY  8'h3f
`define SDR_CH_CR     8'h0d
`define SDR_CH_LF     8'h0a
`define SDR_CH_PLUS   8'h2b
`define SDR_CH_MINUS  8'h2d
`define SDR_CH_A      8'h41
`define SDR_CH_M      8'h4d
`define SDR_CH_C      8'h43
`define SDR_CH_D      8'h44
`define SDR_CH_R      8'h52
`define SDR_CH_X      8'h58
`define SDR_DIG_HI    4'h3
`define SDR_DIG_MAX   4'h9
`define SDR_CRC_TAG   2'h1
`define SDR_CRC_POLY  16'ha001
`define SDR_CRC_INIT  16'h0000
`define SDR_LIM_M     7'h23
`define SDR_LIM_C     7'h4b
`define SDR_ADDR_RST  8'h30
`define SDR_HDR_ADDR  3'h1
`define SDR_HDR_MEAS  3'h5
`define SDR_HDR_CONC  3'h6
`define SDR_KIND_D    2'h0
`define SDR_KIND_R    2'h1
`define SDR_KIND_X    2'h2
`endif

// [src/sdr_crc16.sv]
// Byte-serial reflected CRC-16 accumulator for reply checksums.
// Assumes clear and update are never requested in the same cycle.
`include "sdr_consts.svh"
`default_nettype none
module sdr_crc16
  import sdr_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic       clr_i,
  input  wire logic       upd_i,
  input  wire logic [7:0] byte_i,
  output logic [15:0]     crc_o
);
  import sdr_pkg::*;

  sdr_crc_state_t q;
  sdr_crc_state_t d;

  always_comb
  begin
    logic [15:0] c;
    c = q.crc ^ {8'h00, byte_i};
    d = q;
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `SDR_CRC_POLY) : (c >> 1);
    end
    if (clr_i)
      d.crc = `SDR_CRC_INIT;
    else if (upd_i)
      d.crc = c;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      q <= '0;
    else if (ce_i)
      q <= d;
  end

  assign crc_o = q.crc;
endmodule
`default_nettype wire

// [src/sdr_pkg.sv]
// Types of the sensor command responder: sequencer states and state records.
// Assumes sdr_consts.svh is on the include path.
`default_nettype none
package sdr_pkg;
  typedef enum logic [6:0] {
    SDR_IDLE = 7'h01,
    SDR_HDR  = 7'h02,
    SDR_DATA = 7'h04,
    SDR_PEND = 7'h08,
    SDR_CRC  = 7'h10,
    SDR_CR   = 7'h20,
    SDR_LF   = 7'h40
  } sdr_st_t;

  typedef struct packed {
    sdr_st_t     st;
    logic [7:0]  addr;
    logic [2:0]  rx_n;
    logic [7:0]  rx_a;
    logic [7:0]  rx_c1;
    logic [7:0]  rx_c2;
    logic        run;
    logic        conc;
    logic        crcm;
    logic        srq;
    logic [6:0]  mlim;
    logic [6:0]  lim;
    logic [6:0]  vcnt;
    logic        trunc;
    logic [47:0] hdr;
    logic [2:0]  hdr_n;
    logic        rep_dat;
    logic        rep_crc;
    logic [7:0]  pend;
    logic        plast;
    logic [1:0]  k;
    logic        tx_vld;
    logic [7:0]  tx_chr;
    logic        src_rdy;
    logic        dreq;
    logic [3:0]  didx;
    logic [1:0]  dkind;
    logic        mstart;
    logic        mconc;
    logic        mabort;
  } sdr_state_t;

  typedef struct packed {
    logic [15:0] crc;
  } sdr_crc_state_t;
endpackage
`default_nettype wire

// [src/sdr_responder.sv]
// Command interpreter of a serial-bus sensor: parses commands, steers the
// measurement engine and frames replies character by character.
// Assumes a serial front end on the same clock delivering received characters,
// break detection and a transmit handshake, and a value source streaming data.
// Contract
// - A break during a plain measurement abandons that measurement.
// - Any valid addressed command aborts a running concurrent measurement.
// - Concurrent measurements send no service request; master waits out the time.
// - Data after a plain measurement holds at most 35 characters.
// - Data after a concurrent measurement holds at most 75 characters.
// - Every value carries a leading sign, which also separates values.
// - Data reply: address, signed values, then carriage return and line feed.
// - Checksum variants put a 16-bit checksum before the line end.
// - Continuous reads answer like data replies, values up to 75 characters.
// - Extended command: address, X, optional letters, exclamation mark.
// - Extended replies start with the address and end with the line end.
// - Address query is answered with the current address.
// - Address change adopts the new address and answers with it.
// - Checksum is three characters just before the line end.
`include "sdr_consts.svh"
`default_nettype none
module sdr_responder
  import sdr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        rx_vld_i,
  input  wire logic [7:0]  rx_chr_i,
  input  wire logic        brk_i,
  input  wire logic        tx_rdy_i,
  output logic             tx_vld_o,
  output logic [7:0]       tx_chr_o,
  input  wire logic [11:0] meas_ttt_i,
  input  wire logic [7:0]  meas_nval_i,
  input  wire logic        meas_done_i,
  output logic             meas_start_o,
  output logic             meas_conc_o,
  output logic             meas_abort_o,
  input  wire logic        src_vld_i,
  input  wire logic [7:0]  src_chr_i,
  input  wire logic        src_first_i,
  input  wire logic        src_last_i,
  output logic             src_rdy_o,
  output logic             data_req_o,
  output logic [3:0]       data_idx_o,
  output logic [1:0]       data_kind_o,
  output logic [7:0]       addr_o
);
  import sdr_pkg::*;

  sdr_state_t  q;
  sdr_state_t  d;
  logic        crc_clr;
  logic        crc_upd;
  logic [7:0]  nchr;
  logic [15:0] crc;
  logic        pars;

  sdr_crc16 u_crc (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .clr_i     (crc_clr),
    .upd_i     (crc_upd),
    .byte_i    (nchr),
    .crc_o     (crc)
  );

  assign pars = rx_vld_i && q.st == SDR_IDLE && !brk_i && rx_chr_i == `SDR_CH_BANG;

  always_comb
  begin
    logic slot;
    logic rep;
    logic ins;
    logic room;
    logic [1:0] kd;
    slot = !q.tx_vld || tx_rdy_i;
    rep = 1'b0;
    ins = 1'b0;
    room = 1'b0;
    kd = `SDR_KIND_D;
    d = q;
    crc_clr = 1'b0;
    crc_upd = 1'b0;
    nchr = 8'h00;
    d.mstart = 1'b0;
    d.mabort = 1'b0;
    d.dreq = 1'b0;
    if (q.tx_vld && tx_rdy_i)
      d.tx_vld = 1'b0;
    if (meas_done_i && q.run)
    begin
      d.run = 1'b0;
      d.srq = !q.conc;
    end
    if (brk_i)
    begin
      d.rx_n = 3'h0;
      if (q.run && !q.conc)
      begin
        d.run = 1'b0;
        d.mabort = 1'b1;
      end
    end
    unique case (q.st)
      SDR_IDLE:
      begin
        if (pars)
        begin
          d.rx_n = 3'h0;
          d.rep_dat = 1'b0;
          d.rep_crc = 1'b0;
          d.hdr = {q.addr, 40'h0};
          d.hdr_n = `SDR_HDR_ADDR;
          if (q.rx_a == `SDR_CH_QUERY && q.rx_n == 3'h1)
            rep = 1'b1;
          else if (q.rx_a == q.addr && q.rx_n != 3'h0)
          begin
            rep = 1'b1;
            // A concurrent run ends before the command takes effect
            if (q.run && q.conc && !meas_done_i)
            begin
              d.run = 1'b0;
              d.mabort = 1'b1;
            end
            if (q.rx_n == 3'h1)
              rep = 1'b1;
            else if (q.rx_c1 == `SDR_CH_A && q.rx_n == 3'h3)
            begin
              d.addr = q.rx_c2;
              d.hdr = {q.rx_c2, 40'h0};
            end
            else if ((q.rx_c1 == `SDR_CH_M || q.rx_c1 == `SDR_CH_C) &&
                     (q.rx_n == 3'h2 || (q.rx_n == 3'h3 && q.rx_c2 == `SDR_CH_C)))
            begin
              d.mstart = 1'b1;
              d.run = 1'b1;
              d.srq = 1'b0;
              d.conc = q.rx_c1 == `SDR_CH_C;
              d.mconc = q.rx_c1 == `SDR_CH_C;
              d.crcm = q.rx_n == 3'h3;
              d.mlim = d.conc ? `SDR_LIM_C : `SDR_LIM_M;
              d.hdr = {q.addr, `SDR_DIG_HI, meas_ttt_i[11:8], `SDR_DIG_HI, meas_ttt_i[7:4],
                       `SDR_DIG_HI, meas_ttt_i[3:0], `SDR_DIG_HI, meas_nval_i[7:4],
                       `SDR_DIG_HI, meas_nval_i[3:0]};
              d.hdr_n = `SDR_HDR_CONC;
              if (!d.conc)
              begin
                d.hdr = {q.addr, `SDR_DIG_HI, meas_ttt_i[11:8], `SDR_DIG_HI, meas_ttt_i[7:4],
                         `SDR_DIG_HI, meas_ttt_i[3:0], `SDR_DIG_HI, meas_nval_i[3:0], 8'h00};
                d.hdr_n = `SDR_HDR_MEAS;
              end
            end
            else if ((q.rx_c1 == `SDR_CH_D || q.rx_c1 == `SDR_CH_R) && q.rx_n == 3'h3 &&
                     q.rx_c2[7:4] == `SDR_DIG_HI && q.rx_c2[3:0] <= `SDR_DIG_MAX)
            begin
              kd = (q.rx_c1 == `SDR_CH_D) ? `SDR_KIND_D : `SDR_KIND_R;
              d.dreq = 1'b1;
              d.didx = q.rx_c2[3:0];
              d.dkind = kd;
              d.rep_dat = 1'b1;
              d.rep_crc = (kd == `SDR_KIND_D) && q.crcm;
              d.lim = (kd == `SDR_KIND_D) ? q.mlim : `SDR_LIM_C;
            end
            else if (q.rx_c1 == `SDR_CH_X)
            begin
              d.dreq = 1'b1;
              d.didx = 4'h0;
              d.dkind = `SDR_KIND_X;
              d.rep_dat = 1'b1;
              d.lim = `SDR_LIM_C;
            end
            else
            begin
              // Cancel the reply and undo the abort; a completion in this cycle still ends the run
              rep = 1'b0;
              d.run = q.run && !meas_done_i;
              d.mabort = 1'b0;
            end
          end
        end
        else if (rx_vld_i && !brk_i)
        begin
          // Only three characters are kept; longer extended commands still parse
          if (q.rx_n == 3'h0)
            d.rx_a = rx_chr_i;
          if (q.rx_n == 3'h1)
            d.rx_c1 = rx_chr_i;
          if (q.rx_n == 3'h2)
            d.rx_c2 = rx_chr_i;
          if (q.rx_n != 3'h4)
            d.rx_n = q.rx_n + 3'h1;
        end
        else if (q.srq && q.rx_n == 3'h0)
        begin
          d.srq = 1'b0;
          d.rep_dat = 1'b0;
          d.rep_crc = 1'b0;
          d.hdr = {q.addr, 40'h0};
          d.hdr_n = `SDR_HDR_ADDR;
          rep = 1'b1;
        end
        if (rep)
        begin
          d.st = SDR_HDR;
          crc_clr = 1'b1;
          d.vcnt = 7'h00;
          d.trunc = 1'b0;
          d.k = 2'h0;
        end
      end
      SDR_HDR:
      begin
        if (slot)
        begin
          nchr = q.hdr[47:40];
          crc_upd = 1'b1;
          d.hdr = {q.hdr[39:0], 8'h00};
          d.hdr_n = q.hdr_n - 3'h1;
          if (q.hdr_n == 3'h1)
            d.st = q.rep_dat ? SDR_DATA : SDR_CR;
        end
      end
      SDR_DATA:
      begin
        if (q.src_rdy && src_vld_i)
        begin
          ins = src_first_i && src_chr_i != `SDR_CH_PLUS && src_chr_i != `SDR_CH_MINUS;
          room = (q.vcnt + (ins ? 7'h2 : 7'h1)) <= q.lim;
          if (!q.trunc && room)
          begin
            nchr = ins ? `SDR_CH_PLUS : src_chr_i;
            crc_upd = 1'b1;
            d.vcnt = q.vcnt + (ins ? 7'h2 : 7'h1);
            d.pend = src_chr_i;
            d.plast = src_last_i;
            if (ins)
              d.st = SDR_PEND;
          end
          else
            d.trunc = 1'b1;
          if (src_last_i && d.st == SDR_DATA)
            d.st = q.rep_crc ? SDR_CRC : SDR_CR;
        end
      end
      SDR_PEND:
      begin
        if (slot)
        begin
          nchr = q.pend;
          crc_upd = 1'b1;
          d.st = q.plast ? (q.rep_crc ? SDR_CRC : SDR_CR) : SDR_DATA;
        end
      end
      SDR_CRC:
      begin
        if (slot)
        begin
          // Four bits in the first character and six in each of the next two, each tagged 01 in bits 7:6
          nchr = {`SDR_CRC_TAG, 2'h0, crc[15:12]};
          if (q.k == 2'h1)
            nchr = {`SDR_CRC_TAG, crc[11:6]};
          if (q.k == 2'h2)
            nchr = {`SDR_CRC_TAG, crc[5:0]};
          d.k = q.k + 2'h1;
          if (q.k == 2'h2)
            d.st = SDR_CR;
        end
      end
      SDR_CR:
      begin
        if (slot)
        begin
          nchr = `SDR_CH_CR;
          d.st = SDR_LF;
        end
      end
      SDR_LF:
      begin
        if (slot)
        begin
          nchr = `SDR_CH_LF;
          d.st = SDR_IDLE;
        end
      end
      default:
        d.st = SDR_IDLE;
    endcase
    if (q.st != SDR_IDLE && q.st != SDR_DATA && slot)
    begin
      d.tx_vld = 1'b1;
      d.tx_chr = nchr;
    end
    if (q.st == SDR_DATA && q.src_rdy && src_vld_i && !q.trunc && room)
    begin
      d.tx_vld = 1'b1;
      d.tx_chr = nchr;
    end
    // Ready only with an empty transmit slot, so a taken character waits only in SDR_PEND behind an inserted sign
    d.src_rdy = d.st == SDR_DATA && !d.tx_vld;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.st <= SDR_IDLE;
      q.addr <= `SDR_ADDR_RST;
      q.mlim <= `SDR_LIM_M;
      q.lim <= `SDR_LIM_M;
    end
    else if (ce_i)
      q <= d;
  end

  assign tx_vld_o = q.tx_vld;
  assign tx_chr_o = q.tx_chr;
  assign meas_start_o = q.mstart;
  assign meas_conc_o = q.mconc;
  assign meas_abort_o = q.mabort;
  assign src_rdy_o = q.src_rdy;
  assign data_req_o = q.dreq;
  assign data_idx_o = q.didx;
  assign data_kind_o = q.dkind;
  assign addr_o = q.addr;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_BRK_ABORT: assert property (ce_i && brk_i && q.run && !q.conc |=> meas_abort_o && !q.run)
    else $error("break did not abandon plain measurement");
  AST_CONC_ABORT: assert property (ce_i && pars && q.rx_a == q.addr && q.run && q.conc &&
      !meas_done_i && (q.rx_n == 3'h1 || (q.rx_n == 3'h3 && q.rx_c1 == `SDR_CH_D &&
      q.rx_c2[7:4] == `SDR_DIG_HI && q.rx_c2[3:0] <= `SDR_DIG_MAX))
      |=> meas_abort_o && !q.run)
    else $error("valid command did not abort concurrent run");
  AST_NO_SRQ: assert property (ce_i && meas_done_i && q.run && q.conc |=> !q.srq)
    else $error("service request after concurrent run");
  AST_LIMIT: assert property (q.vcnt <= q.lim)
    else $error("value characters over limit");
  AST_SIGN: assert property (q.st == SDR_PEND |-> tx_vld_o && tx_chr_o == `SDR_CH_PLUS)
    else $error("value sent without sign");
  AST_CR_LF: assert property (q.st == SDR_LF |-> tx_vld_o && tx_chr_o == `SDR_CH_CR)
    else $error("line feed not preceded by carriage return");
  AST_CRC_TAG: assert property (q.st == SDR_CR && q.rep_crc |-> q.k == 2'h3 &&
      tx_chr_o[7:6] == `SDR_CRC_TAG)
    else $error("checksum not before line end");
  AST_ADDR_FIRST: assert property ($rose(q.st == SDR_HDR) |-> q.hdr[47:40] == q.addr)
    else $error("reply does not open with address");
  AST_ADDR_CHG: assert property (ce_i && pars && q.rx_a == q.addr && q.rx_n == 3'h3 &&
      q.rx_c1 == `SDR_CH_A |=> q.addr == $past(q.rx_c2) ##1 tx_chr_o == q.addr)
    else $error("address change not adopted");
  AST_IGNORE: assert property (ce_i && pars && q.rx_a != q.addr && q.rx_a != `SDR_CH_QUERY
      |=> q.st == SDR_IDLE && !data_req_o && !meas_start_o)
    else $error("foreign command answered");
  AST_EXT: assert property (ce_i && pars && q.rx_a == q.addr && q.rx_n >= 3'h2 &&
      q.rx_c1 == `SDR_CH_X |=> data_req_o && data_kind_o == `SDR_KIND_X)
    else $error("extended command not dispatched");
endmodule
`default_nettype wire

// [tb/sdr_logger_model.sv]
// Data logger model on the far side: sends commands, optionally after a break,
// and collects reply characters. Assumes send is called just after a rising edge.
`default_nettype none
module sdr_logger_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       slow_i,
  input  wire logic       tx_vld_i,
  input  wire logic [7:0] tx_chr_i,
  output logic            rx_vld_o,
  output logic [7:0]      rx_chr_o,
  output logic            brk_o,
  output logic            tx_rdy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rsp[$];
  initial
  begin
    rx_vld_o = 1'b0;
    rx_chr_o = 8'h00;
    brk_o    = 1'b0;
    tx_rdy_o = 1'b1;
  end
  // Slow mode accepts every other cycle, stalling the reply path
  always @(posedge ref_clk_i)
  begin
    if (tx_vld_i && tx_rdy_o)
      rsp.push_back(tx_chr_i);
    tx_rdy_o <= slow_i ? ~tx_rdy_o : 1'b1;
  end
  task automatic send(input string s, input bit brk);
    int i;
    if (brk)
    begin
      brk_o <= 1'b1;
      @(posedge ref_clk_i);
      brk_o <= 1'b0;
      @(posedge ref_clk_i);
    end
    for (i = 0; i < s.len(); i++)
    begin
      rx_vld_o <= 1'b1;
      rx_chr_o <= s[i];
      @(posedge ref_clk_i);
    end
    rx_vld_o <= 1'b0;
    // Released line shows a changed level, never the last character
    rx_chr_o <= ~rx_chr_o;
  endtask
endmodule
`default_nettype wire

// [tb/sdr_responder_test.sv]
// Self-checking bench of the command responder with a logger model and a
// value source. Assumes the responder and its package are compiled first.
`include "sdr_consts.svh"
`default_nettype none
module sdr_responder_test;
  import sdr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, resetn_i, ce_i, rx_vld_i, brk_i, tx_rdy_i, tx_vld_o;
  logic [7:0]  rx_chr_i, tx_chr_o, meas_nval_i, src_chr_i, addr_o;
  logic [11:0] meas_ttt_i;
  logic        meas_done_i, meas_start_o, meas_conc_o, meas_abort_o, slow;
  logic        src_vld_i, src_first_i, src_last_i, src_rdy_o, data_req_o, nf;
  logic [3:0]  data_idx_o;
  logic [1:0]  data_kind_o;
  logic [7:0]  sq[$];
  bit          fq[$];
  string       src_text;
  string       lng;
  int          n_fail, check_count, n_start, n_abort, k;
  sdr_responder dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .rx_vld_i(rx_vld_i), .rx_chr_i(rx_chr_i), .brk_i(brk_i), .tx_rdy_i(tx_rdy_i),
    .tx_vld_o(tx_vld_o), .tx_chr_o(tx_chr_o), .meas_ttt_i(meas_ttt_i),
    .meas_nval_i(meas_nval_i), .meas_done_i(meas_done_i), .meas_start_o(meas_start_o),
    .meas_conc_o(meas_conc_o), .meas_abort_o(meas_abort_o), .src_vld_i(src_vld_i),
    .src_chr_i(src_chr_i), .src_first_i(src_first_i), .src_last_i(src_last_i),
    .src_rdy_o(src_rdy_o), .data_req_o(data_req_o), .data_idx_o(data_idx_o),
    .data_kind_o(data_kind_o), .addr_o(addr_o));
  sdr_logger_model lgr (.ref_clk_i(ref_clk_i), .slow_i(slow), .tx_vld_i(tx_vld_o),
    .tx_chr_i(tx_chr_o), .rx_vld_o(rx_vld_i), .rx_chr_o(rx_chr_i), .brk_o(brk_i),
    .tx_rdy_o(tx_rdy_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // Value source: a comma marks the start of a value in src_text
  always @(posedge ref_clk_i)
  begin
    if (src_vld_i && src_rdy_o)
    begin
      void'(sq.pop_front());
      void'(fq.pop_front());
    end
    if (data_req_o)
    begin
      nf = 1'b0;
      for (k = 0; k < src_text.len(); k++)
        if (src_text[k] == 8'h2c)
          nf = 1'b1;
        else
        begin
          sq.push_back(src_text[k]);
          fq.push_back(nf);
          nf = 1'b0;
        end
    end
    src_vld_i   <= sq.size() != 0;
    src_chr_i   <= (sq.size() != 0) ? sq[0] : ~src_chr_i;
    src_first_i <= (fq.size() != 0) ? fq[0] : 1'b0;
    src_last_i  <= sq.size() == 1;
    n_start     <= n_start + int'(meas_start_o);
    n_abort     <= n_abort + int'(meas_abort_o);
  end
  task automatic check_str(input string got, input string exp, input string msg);
    check_count++;
    if (got != exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got [%s]", $time, msg, got);
    end
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask
  // Collects one reply up to its line feed; empty if none comes in time
  task automatic reply(output string s);
    int w;
    s = "";
    for (w = 0; w < 2000; w++)
    begin
      @(negedge ref_clk_i);
      if (lgr.rsp.size() != 0 && lgr.rsp[$] == `SDR_CH_LF && tx_vld_o === 1'b0)
        break;
    end
    foreach (lgr.rsp[i])
      s = $sformatf("%s%c", s, lgr.rsp[i]);
    lgr.rsp.delete();
    @(posedge ref_clk_i);
  endtask
  task automatic cmd(input string c, input string exp);
    string got;
    lgr.send(c, 1'b1);
    reply(got);
    check_str(got, exp, c);
  endtask
  task automatic done_pulse();
    meas_done_i <= 1'b1;
    @(posedge ref_clk_i);
    meas_done_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  function automatic string rep(input string u, input int n);
    string r;
    r = "";
    repeat (n) r = {r, u};
    return r;
  endfunction
  function automatic string crc3(input string s);
    logic [15:0] c;
    int          i;
    c = 16'h0000;
    for (i = 0; i < s.len(); i++)
    begin
      c = c ^ {8'h00, s[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return $sformatf("%c%c%c", {4'h4, c[15:12]}, {2'h1, c[11:6]}, {2'h1, c[5:0]});
  endfunction
  task automatic t_addr();
    cmd("?!", "0\r\n");
    cmd("0A5!", "5\r\n");
    check_val(addr_o, 8'h35, "address");
    cmd("0M!", "");
    check_val(8'(n_start), 8'h00, "start count");
    cmd("5A0!", "0\r\n");
    $display("test address done");
  endtask
  task automatic t_conc();
    string got;
    int    a0;
    meas_ttt_i  <= 12'h010;
    meas_nval_i <= 8'h10;
    cmd("0C!", "001010\r\n");
    check_val(8'(meas_conc_o), 8'h01, "concurrent kind");
    a0 = n_abort;
    cmd("0!", "0\r\n");
    check_val(8'(n_abort - a0), 8'h01, "abort count");
    cmd("0C!", "001010\r\n");
    done_pulse();
    reply(got);
    check_str(got, "", "service request");
    src_text = rep(",+123", 20);
    slow     <= 1'b1;
    cmd("0D1!", {"0", lng.substr(0, 74), "\r\n"});
    slow     <= 1'b0;
    check_val(8'(data_idx_o), 8'h01, "index");
    $display("test concurrent done");
  endtask
  task automatic t_plain();
    int a0;
    meas_ttt_i  <= 12'h035;
    meas_nval_i <= 8'h02;
    cmd("0M!", "00352\r\n");
    check_val(8'(meas_conc_o), 8'h00, "plain kind");
    done_pulse();
    cmd("", "0\r\n");
    src_text = ",.859,+3.54";
    cmd("0D0!", "0+.859+3.54\r\n");
    check_val(8'(data_kind_o), 8'h00, "kind");
    cmd("0M!", "00352\r\n");
    a0 = n_abort;
    lgr.send("", 1'b1);
    repeat (4) @(posedge ref_clk_i);
    check_val(8'(n_abort - a0), 8'h01, "break abort");
    cmd("0M!", "00352\r\n");
    done_pulse();
    cmd("", "0\r\n");
    src_text = rep(",+123", 20);
    cmd("0D0!", {"0", lng.substr(0, 34), "\r\n"});
    $display("test plain done");
  endtask
  task automatic t_crc();
    cmd("0MC!", "00352\r\n");
    done_pulse();
    cmd("", "0\r\n");
    src_text = ",+1.5,-2";
    cmd("0D0!", {"0+1.5-2", crc3("0+1.5-2"), "\r\n"});
    $display("test checksum done");
  endtask
  task automatic t_rx();
    src_text = rep(",+123", 20);
    cmd("0R3!", {"0", lng.substr(0, 74), "\r\n"});
    check_val(8'(data_idx_o), 8'h03, "read index");
    check_val(8'(data_kind_o), 8'h01, "read kind");
    src_text = ",7";
    cmd("0XAB!", "0+7\r\n");
    check_val(8'(data_kind_o), 8'h02, "extended kind");
    $display("test read and extended done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    ref_clk_i   = 1'b0;
    resetn_i    = 1'b0;
    ce_i        = 1'b1;
    meas_ttt_i  = 12'h000;
    meas_nval_i = 8'h00;
    meas_done_i = 1'b0;
    slow        = 1'b0;
    src_vld_i   = 1'b0;
    src_chr_i   = 8'h00;
    src_first_i = 1'b0;
    src_last_i  = 1'b0;
    n_fail      = 0;
    check_count = 0;
    n_start     = 0;
    n_abort     = 0;
    lng         = rep("+123", 20);
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    check_val(addr_o, `SDR_ADDR_RST, "reset address");
    t_addr();
    t_conc();
    t_plain();
    t_crc();
    t_rx();
    give_verdict();
  end
  // Tests need well under 40000 cycles
  initial
  begin
    repeat (80000) @(posedge ref_clk_i);
    n_fail++;
    $display("wrong value at %0t: run hung", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
